// ### rtl/sbc_core.sv
// Arbiter, register file, interrupt collection and clock select of the bus core
`timescale 1ns/1ps
`include "sbc_params.svh"

module sbc_core #(
  parameter logic [1:0]          PRIO_HOST = `SBC_PRIO_MED,
  parameter logic [1:0]          PRIO_FAB  = `SBC_PRIO_MED,
  parameter sbc_pkg::sbc_clk_src_e CLK_OPT = sbc_pkg::SBC_CLK_CONFIG
) (
  input  wire logic                     MCLK,
  input  wire logic                     RESET,
  input  wire logic                     BUS_CORE_RESET_N,
  input  wire logic                     CFG_REQ,
  input  wire logic [`SBC_ADDR_W-1:0]   CFG_ADDR,
  input  wire logic                     CFG_WE,
  input  wire logic [`SBC_DATA_W-1:0]   CFG_WDATA,
  input  wire logic                     HOST_REQ,
  input  wire logic [`SBC_ADDR_W-1:0]   HOST_ADDR,
  input  wire logic                     HOST_WE,
  input  wire logic [`SBC_DATA_W-1:0]   HOST_WDATA,
  input  wire logic                     FAB_REQ,
  input  wire logic [`SBC_ADDR_W-1:0]   FAB_ADDR,
  input  wire logic                     FAB_WE,
  input  wire logic [`SBC_DATA_W-1:0]   FAB_WDATA,
  output logic                          CFG_GNT,
  output logic                          HOST_GNT,
  output logic                          FAB_GNT,
  output logic [`SBC_DATA_W-1:0]        RD_DATA,
  output logic                          RD_VALID,
  output logic                          SLV_STB,
  output logic [`SBC_ADDR_W-1:0]        SLV_ADDR,
  output logic                          SLV_WE,
  output logic [`SBC_DATA_W-1:0]        SLV_WDATA,
  input  wire logic                     SERIAL_CODING_IRQ,
  input  wire logic                     HOST_PORT_IRQ,
  input  wire logic                     CONFIG_ERR_IRQ,
  input  wire logic                     CONFIG_DATA_IRQ,
  input  wire logic                     FABRIC_MASTER_IRQ,
  input  wire logic                     FABRIC_SLAVE_IRQ,
  input  wire logic                     FABRIC_IRQ_IN,
  output logic [`SBC_DATA_W-1:0]        CAUSE_OUT,
  output logic                          HOST_IRQ_OUT_N,
  output logic                          FABRIC_IRQ_OUT,
  input  wire logic [`SBC_MODE_W-1:0]   CFG_MODE,
  input  wire logic                     CONFIG_DONE,
  input  wire logic                     CONFIG_BUSY,
  output sbc_pkg::sbc_clk_src_e         BUS_CLK_SEL,
  output logic                          SYNC_CLK
);

  // ************************************************************
  // Reset and shared state
  // ************************************************************
  logic                         rst;
  sbc_pkg::sbc_state_e          state_reg;
  sbc_pkg::sbc_master_e         owner_next;
  logic                         last_fab_reg;
  logic [`SBC_ADDR_W-1:0]       addr_reg;
  logic                         we_reg;
  logic [`SBC_DATA_W-1:0]       wdata_reg;
  logic [`SBC_DATA_W-1:0]       cause_reg;
  logic [`SBC_DATA_W-1:0]       fab_en_reg;
  logic [`SBC_DATA_W-1:0]       host_en_reg;
  logic [`SBC_NUM_IRQ-1:0]      src_raw;
  logic [`SBC_NUM_IRQ-1:0]      src_meta_reg;
  logic [`SBC_NUM_IRQ-1:0]      src_sync_reg;
  logic [`SBC_NUM_IRQ-1:0]      src_prev_reg;
  logic [`SBC_NUM_IRQ-1:0]      src_rise;
  logic [`SBC_DATA_W-1:0]       clear_mask;
  logic                         access;
  logic                         hit_cause;
  logic                         hit_fab_en;
  logic                         hit_host_en;
  logic                         host_wins;

  assign rst = RESET | ~BUS_CORE_RESET_N;

  // ************************************************************
  // Arbitration
  // ************************************************************
  always_comb begin
    host_wins = 1'b0;
    if (HOST_REQ && FAB_REQ) begin
      if (PRIO_HOST != PRIO_FAB) begin
        host_wins = (PRIO_HOST > PRIO_FAB);
      end else begin
        host_wins = last_fab_reg;
      end
    end else begin
      host_wins = HOST_REQ;
    end
  end

  always_comb begin
    owner_next = sbc_pkg::SBC_MST_NONE;
    if (CFG_REQ) begin
      owner_next = sbc_pkg::SBC_MST_CFG;
    end else if (host_wins) begin
      owner_next = sbc_pkg::SBC_MST_HOST;
    end else if (FAB_REQ) begin
      owner_next = sbc_pkg::SBC_MST_FAB;
    end
  end

  always_ff @(posedge MCLK) begin
    if (rst) begin
      state_reg <= sbc_pkg::SBC_ST_IDLE;
    end else begin
      case (state_reg)
        sbc_pkg::SBC_ST_IDLE: begin
          if (owner_next != sbc_pkg::SBC_MST_NONE) begin
            state_reg <= sbc_pkg::SBC_ST_ACCESS;
          end
        end
        sbc_pkg::SBC_ST_ACCESS: begin
          state_reg <= sbc_pkg::SBC_ST_IDLE;
        end
        default: begin
          state_reg <= sbc_pkg::SBC_ST_IDLE;
        end
      endcase
    end
  end

  // Grants are one-cycle pulses taken straight from flops
  always_ff @(posedge MCLK) begin
    if (rst || state_reg != sbc_pkg::SBC_ST_IDLE) begin
      CFG_GNT  <= 1'h0;
      HOST_GNT <= 1'h0;
      FAB_GNT  <= 1'h0;
    end else begin
      CFG_GNT  <= (owner_next == sbc_pkg::SBC_MST_CFG);
      HOST_GNT <= (owner_next == sbc_pkg::SBC_MST_HOST);
      FAB_GNT  <= (owner_next == sbc_pkg::SBC_MST_FAB);
    end
  end

  // Round-robin pointer remembers which user port was served last
  always_ff @(posedge MCLK) begin
    if (rst) begin
      last_fab_reg <= 1'b1;
    end else if (state_reg == sbc_pkg::SBC_ST_IDLE) begin
      if (owner_next == sbc_pkg::SBC_MST_HOST) begin
        last_fab_reg <= 1'b0;
      end else if (owner_next == sbc_pkg::SBC_MST_FAB) begin
        last_fab_reg <= 1'b1;
      end
    end
  end

  // Fields of the winning request are held for the access cycle
  always_ff @(posedge MCLK) begin
    if (rst) begin
      addr_reg  <= '0;
      we_reg    <= 1'b0;
      wdata_reg <= '0;
    end else if (state_reg == sbc_pkg::SBC_ST_IDLE) begin
      case (owner_next)
        sbc_pkg::SBC_MST_CFG: begin
          addr_reg  <= CFG_ADDR;
          we_reg    <= CFG_WE;
          wdata_reg <= CFG_WDATA;
        end
        sbc_pkg::SBC_MST_HOST: begin
          addr_reg  <= HOST_ADDR;
          we_reg    <= HOST_WE;
          wdata_reg <= HOST_WDATA;
        end
        sbc_pkg::SBC_MST_FAB: begin
          addr_reg  <= FAB_ADDR;
          we_reg    <= FAB_WE;
          wdata_reg <= FAB_WDATA;
        end
        default: begin
          we_reg <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // Address decode and register file
  // ************************************************************
  assign access      = (state_reg == sbc_pkg::SBC_ST_ACCESS);
  assign hit_cause   = (addr_reg == `SBC_OFS_CAUSE);
  assign hit_fab_en  = (addr_reg == `SBC_OFS_FAB_EN);
  assign hit_host_en = (addr_reg == `SBC_OFS_HOST_EN);

  always_ff @(posedge MCLK) begin
    if (rst) begin
      fab_en_reg <= `SBC_EN_RST;
    end else if (access && we_reg && hit_fab_en && FAB_GNT) begin
      fab_en_reg <= wdata_reg & `SBC_IRQ_MASK;
    end
  end

  always_ff @(posedge MCLK) begin
    if (rst) begin
      host_en_reg <= `SBC_EN_RST;
    end else if (access && we_reg && hit_host_en && HOST_GNT) begin
      host_en_reg <= wdata_reg & `SBC_IRQ_MASK;
    end
  end

  always_ff @(posedge MCLK) begin
    if (rst) begin
      RD_DATA  <= '0;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= access && !we_reg;
      if (access && !we_reg) begin
        if (hit_cause) begin
          RD_DATA <= cause_reg;
        end else if (hit_fab_en) begin
          RD_DATA <= fab_en_reg;
        end else if (hit_host_en) begin
          RD_DATA <= host_en_reg;
        end else begin
          RD_DATA <= '0;
        end
      end
    end
  end

  // Accesses outside the core registers go out to the slave side
  always_ff @(posedge MCLK) begin
    if (rst) begin
      SLV_STB   <= 1'b0;
      SLV_ADDR  <= '0;
      SLV_WE    <= 1'b0;
      SLV_WDATA <= '0;
    end else begin
      SLV_STB <= access && !(hit_cause || hit_fab_en || hit_host_en);
      if (access) begin
        SLV_ADDR  <= addr_reg;
        SLV_WE    <= we_reg;
        SLV_WDATA <= wdata_reg;
      end
    end
  end

  // ************************************************************
  // Interrupt sources: synchroniser and edge detect per bit
  // ************************************************************
  assign src_raw = {FABRIC_IRQ_IN, FABRIC_SLAVE_IRQ, FABRIC_MASTER_IRQ, CONFIG_DATA_IRQ,
                    CONFIG_ERR_IRQ, HOST_PORT_IRQ, SERIAL_CODING_IRQ, 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < `SBC_NUM_IRQ; gi = gi + 1) begin : g_src
      always_ff @(posedge MCLK) begin
        if (rst) begin
          src_meta_reg[gi] <= 1'b0;
          src_sync_reg[gi] <= 1'b0;
          src_prev_reg[gi] <= 1'b0;
        end else begin
          src_meta_reg[gi] <= src_raw[gi];
          src_sync_reg[gi] <= src_meta_reg[gi];
          src_prev_reg[gi] <= src_sync_reg[gi];
        end
      end
      assign src_rise[gi] = src_sync_reg[gi] & ~src_prev_reg[gi];
    end
  endgenerate

  // ************************************************************
  // Cause register, write one to clear, set wins
  // ************************************************************
  assign clear_mask = (access && we_reg && hit_cause) ? wdata_reg : '0;

  always_ff @(posedge MCLK) begin
    if (rst) begin
      cause_reg <= `SBC_CAUSE_RST;
    end else begin
      cause_reg <= ((cause_reg & ~clear_mask) | src_rise) & `SBC_IRQ_MASK;
    end
  end

  always_ff @(posedge MCLK) begin
    if (rst) begin
      CAUSE_OUT      <= `SBC_CAUSE_RST;
      HOST_IRQ_OUT_N <= 1'b1;
      FABRIC_IRQ_OUT <= 1'b0;
    end else begin
      CAUSE_OUT      <= cause_reg;
      HOST_IRQ_OUT_N <= ~|(cause_reg & host_en_reg);
      FABRIC_IRQ_OUT <= |(cause_reg & fab_en_reg);
    end
  end

  // ************************************************************
  // Bus clock source select and synchronous clock output
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (rst) begin
      BUS_CLK_SEL <= sbc_pkg::SBC_CLK_CONFIG;
    end else if (!CONFIG_DONE || CONFIG_BUSY) begin
      if (CFG_MODE == `SBC_MODE_HOSTPORT) begin
        BUS_CLK_SEL <= sbc_pkg::SBC_CLK_HOST;
      end else begin
        BUS_CLK_SEL <= sbc_pkg::SBC_CLK_CONFIG;
      end
    end else begin
      BUS_CLK_SEL <= CLK_OPT;
    end
  end

  always_ff @(posedge MCLK) begin
    if (rst) begin
      SYNC_CLK <= 1'b0;
    end else begin
      SYNC_CLK <= ~SYNC_CLK;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_one_grant: assert property (@(posedge MCLK) disable iff (rst)
    $onehot0({CFG_GNT, HOST_GNT, FAB_GNT}))
    else $error("more than one grant");

  a_cfg_first: assert property (@(posedge MCLK) disable iff (rst)
    (state_reg == sbc_pkg::SBC_ST_IDLE && CFG_REQ) |=> CFG_GNT)
    else $error("config request not granted first");

  a_rr_equal: assert property (@(posedge MCLK) disable iff (rst)
    (PRIO_HOST == PRIO_FAB && state_reg == sbc_pkg::SBC_ST_IDLE && !CFG_REQ && HOST_REQ && FAB_REQ)
    |=> (HOST_GNT == $past(last_fab_reg)))
    else $error("round robin order broken");

  a_high_prio: assert property (@(posedge MCLK) disable iff (rst)
    (PRIO_HOST != PRIO_FAB && state_reg == sbc_pkg::SBC_ST_IDLE && !CFG_REQ && HOST_REQ && FAB_REQ)
    |=> (HOST_GNT == (PRIO_HOST > PRIO_FAB)) && (FAB_GNT == (PRIO_FAB > PRIO_HOST)))
    else $error("higher level master not granted");

  a_cause_set: assert property (@(posedge MCLK) disable iff (rst)
    $rose(src_sync_reg[7]) |=> cause_reg[7])
    else $error("rising source did not set cause");

  a_cause_clear: assert property (@(posedge MCLK) disable iff (rst)
    (access && we_reg && hit_cause && wdata_reg[6] && !src_rise[6]) |=> !cause_reg[6])
    else $error("write one did not clear cause");

  a_host_irq: assert property (@(posedge MCLK) disable iff (rst)
    (|(cause_reg & host_en_reg)) |=> !HOST_IRQ_OUT_N)
    else $error("host interrupt not asserted low");

  a_fab_irq_idle: assert property (@(posedge MCLK) disable iff (rst)
    !(|(cause_reg & fab_en_reg)) |=> !FABRIC_IRQ_OUT)
    else $error("fabric interrupt stuck high");

  a_en_owner: assert property (@(posedge MCLK) disable iff (rst)
    (access && we_reg && hit_host_en && !HOST_GNT) |=> $stable(host_en_reg))
    else $error("host enable written by other port");

  a_clk_cfg: assert property (@(posedge MCLK) disable iff (rst)
    (CONFIG_BUSY && CFG_MODE != `SBC_MODE_HOSTPORT) |=> BUS_CLK_SEL == sbc_pkg::SBC_CLK_CONFIG)
    else $error("bus clock not config clock during configuration");

endmodule

// ### rtl/sbc_params.svh
// Constants for the system bus core control block
// Functional notes
// - At most one master holds the bus at any moment, highest priority wins.
// - Configuration logic requests beat every user master port.
// - Equal priorities mean a fair round-robin grant among requesters.
// - Each master port has a build-time priority: low 1, medium 2, high 3.
// - A waiting master of higher level is granted before any lower one.
// - Waiting masters of one level share the grant in round-robin order.
// - The bus decodes an 18-bit byte address, a 256 Kbyte space.
// - A clock output synchronous to the bus clock is driven for fabric logic.
// - Crossing from peripheral clock domains is synchronised inside the core.
// - Before configuration the bus clock source follows the mode pins.
// - After configuration the source is a build-time choice of three clocks.
// - Before load and during configuration the source is the config clock, except in host-port mode.
// - Host-port programming uses the host port clock during configuration.
// - Fabric clock option takes the bus clock from the fabric clock input.
// - Fabric, configuration and serial coding sources each own a cause bit.
// - A raised interrupt sets its cause bit; writing 1 clears it.
// - Clearing a cause bit never touches the originating source.
// - Fabric enable sits at 0x12 and host enable at 0x13.
// - Enabled causes drive host output low and fabric output high.
// - Cause and enable share bit positions 1 to 7; bit 0 unused.
// - Only fabric master writes fabric enable; only host port writes host enable.
// - A rising edge on a source sets its cause bit.
// - The active-low bus reset clears all core logic.
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH

`define SBC_ADDR_W        18
`define SBC_DATA_W        8
`define SBC_NUM_IRQ       8
`define SBC_OFS_CAUSE     18'h00010
`define SBC_OFS_FAB_EN    18'h00012
`define SBC_OFS_HOST_EN   18'h00013
`define SBC_CAUSE_RST     8'h00
`define SBC_EN_RST        8'h00
`define SBC_IRQ_MASK      8'hFE
`define SBC_PRIO_LOW      2'h1
`define SBC_PRIO_MED      2'h2
`define SBC_PRIO_HIGH     2'h3
`define SBC_MODE_W        3
`define SBC_MODE_HOSTPORT 3'h5
`define SBC_SYNC_STAGES   2

`endif

// ### rtl/sbc_pkg.sv
// Types shared by the system bus core control block
package sbc_pkg;

  typedef enum logic [1:0] {
    SBC_CLK_CONFIG,
    SBC_CLK_HOST,
    SBC_CLK_FABRIC
  } sbc_clk_src_e;

  typedef enum logic [1:0] {
    SBC_MST_NONE,
    SBC_MST_CFG,
    SBC_MST_HOST,
    SBC_MST_FAB
  } sbc_master_e;

  typedef enum {
    SBC_ST_IDLE,
    SBC_ST_ACCESS
  } sbc_state_e;

endpackage

// ### verif/sbc_src_model.sv
// Model of the peripherals that raise interrupts on the bus core
`timescale 1ns/1ps

module sbc_src_model (
  input  wire logic       mclk,
  output logic      [7:1] src
);
  initial src = '0;

  // Source stays high for many cycles so its edge crosses the sync chain
  task automatic raise(input int b);
    @(posedge mclk);
    #1 src[b] = 1'b1;
  endtask

  task automatic drop(input int b);
    @(posedge mclk);
    #1 src[b] = 1'b0;
  endtask
endmodule

// ### verif/tb_top.sv
// Self-checking testbench of the system bus core control block
`timescale 1ns/1ps
`include "sbc_params.svh"

module tb_top;
  logic                  MCLK = 0, RESET = 1, BUS_CORE_RESET_N = 1;
  logic                  req [3];
  logic                  we  [3];
  logic [17:0]           adr [3];
  logic [7:0]            wd  [3];
  wire                   CFG_REQ = req[0], HOST_REQ = req[1], FAB_REQ = req[2];
  wire                   CFG_WE = we[0], HOST_WE = we[1], FAB_WE = we[2];
  wire [17:0]            CFG_ADDR = adr[0], HOST_ADDR = adr[1], FAB_ADDR = adr[2];
  wire [7:0]             CFG_WDATA = wd[0], HOST_WDATA = wd[1], FAB_WDATA = wd[2];
  logic                  CFG_GNT, HOST_GNT, FAB_GNT, RD_VALID, SLV_STB, SLV_WE;
  logic                  HOST_IRQ_OUT_N, FABRIC_IRQ_OUT, SYNC_CLK;
  logic [7:0]            RD_DATA, SLV_WDATA, CAUSE_OUT;
  logic [17:0]           SLV_ADDR;
  sbc_pkg::sbc_clk_src_e BUS_CLK_SEL;
  logic [2:0]            CFG_MODE = 0;
  logic                  CONFIG_DONE = 0, CONFIG_BUSY = 0;
  wire  [7:1]            src;
  wire                   SERIAL_CODING_IRQ = src[1], HOST_PORT_IRQ = src[2], CONFIG_ERR_IRQ = src[3];
  wire                   CONFIG_DATA_IRQ = src[4], FABRIC_MASTER_IRQ = src[5];
  wire                   FABRIC_SLAVE_IRQ = src[6], FABRIC_IRQ_IN = src[7];
  wire  [2:0]            gnt = {FAB_GNT, HOST_GNT, CFG_GNT};
  logic [2:0]            g2;
  int                    n_errors = 0, tests_run = 0;

  always #2.5 MCLK = ~MCLK;

  sbc_core #(.CLK_OPT(sbc_pkg::SBC_CLK_FABRIC)) dut (.*);

  // Second core with unequal priorities, only its grants are watched
  sbc_core #(.PRIO_HOST(`SBC_PRIO_LOW), .PRIO_FAB(`SBC_PRIO_HIGH)) dut_prio (.*,
    .CFG_GNT(g2[0]), .HOST_GNT(g2[1]), .FAB_GNT(g2[2]), .RD_DATA(), .RD_VALID(), .SLV_STB(),
    .SLV_ADDR(), .SLV_WE(), .SLV_WDATA(), .CAUSE_OUT(), .HOST_IRQ_OUT_N(), .FABRIC_IRQ_OUT(),
    .BUS_CLK_SEL(), .SYNC_CLK());

  sbc_src_model src_mdl (.mclk(MCLK), .src(src));

  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wait_gnt();
    int n;
    n = 0;
    while (gnt === 3'b000 && n < 20) begin
      @(posedge MCLK);
      #1 n++;
    end
    chk("grant seen", 1, n < 20);
  endtask

  // One transfer: hold request until grant, drop it at the next edge
  task automatic bus(input int p, input logic [17:0] a, input logic w, input logic [7:0] d);
    @(posedge MCLK);
    #1 req[p] = 1;
    adr[p] = a;
    we[p] = w;
    wd[p] = d;
    wait_gnt();
    @(posedge MCLK);
    #1 req[p] = 0;
  endtask

  task automatic rd(input int p, input logic [17:0] a, input logic [7:0] exp);
    bus(p, a, 0, 0);
    chk("read valid", 1, RD_VALID);
    chk("read data", exp, RD_DATA);
  endtask

  task automatic t_reset();
    rd(1, `SBC_OFS_CAUSE, `SBC_CAUSE_RST);
    rd(1, `SBC_OFS_FAB_EN, `SBC_EN_RST);
    rd(2, `SBC_OFS_HOST_EN, `SBC_EN_RST);
    chk("host irq", 1, HOST_IRQ_OUT_N);
    chk("fabric irq", 0, FABRIC_IRQ_OUT);
  endtask

  // Raise n requests at once and expect grants in the order o
  task automatic arb(input int n, input int o[3]);
    @(posedge MCLK);
    #1;
    for (int k = 0; k < n; k++) begin
      req[o[k]] = 1;
      adr[o[k]] = `SBC_OFS_CAUSE;
      we[o[k]] = 0;
    end
    for (int k = 0; k < n; k++) begin
      @(posedge MCLK);
      #1 wait_gnt();
      chk("single grant", 1, $onehot(gnt));
      chk("grant order", 3'b001 << o[k], gnt);
      if (k == 0 && n == 2) chk("priority grant", 3'b100, g2);
      @(posedge MCLK);
      #1 req[o[k]] = 0;
    end
  endtask

  task automatic t_arb();
    arb(3, '{0, 1, 2});
    arb(2, '{1, 2, 0});
    rd(1, `SBC_OFS_CAUSE, 0);
    arb(2, '{2, 1, 0});
  endtask

  task automatic t_slave();
    bus(2, 18'h3FFFF, 1, 8'hA5);
    chk("slave strobe", 1, SLV_STB);
    chk("slave addr", 18'h3FFFF, SLV_ADDR);
    chk("slave we", 1, SLV_WE);
    chk("slave data", 8'hA5, SLV_WDATA);
    rd(1, 18'h00100, 8'h00);
  endtask

  task automatic t_regs();
    bus(2, `SBC_OFS_FAB_EN, 1, 8'hFF);
    bus(1, `SBC_OFS_HOST_EN, 1, 8'h80);
    bus(1, `SBC_OFS_FAB_EN, 1, 8'h00);
    bus(2, `SBC_OFS_HOST_EN, 1, 8'hFF);
    bus(0, `SBC_OFS_FAB_EN, 1, 8'h00);
    rd(1, `SBC_OFS_FAB_EN, `SBC_IRQ_MASK);
    rd(2, `SBC_OFS_HOST_EN, 8'h80);
  endtask

  // Each source in turn: set, forward, read, clear while source stays high
  task automatic t_irq();
    int n;
    for (int b = 1; b < 8; b++) begin
      src_mdl.raise(b);
      n = 0;
      while (FABRIC_IRQ_OUT !== 1'b1 && n < 10) begin
        @(posedge MCLK);
        #1 n++;
      end
      chk("fabric irq set", 1, FABRIC_IRQ_OUT);
      chk("host irq set", b != 7, HOST_IRQ_OUT_N);
      chk("cause out", 8'h01 << b, CAUSE_OUT);
      rd(1, `SBC_OFS_CAUSE, 8'h01 << b);
      bus(1, `SBC_OFS_CAUSE, 1, 8'h01 << b);
      repeat (2) @(posedge MCLK);
      #1 chk("fabric irq clear", 0, FABRIC_IRQ_OUT);
      chk("host irq clear", 1, HOST_IRQ_OUT_N);
      rd(2, `SBC_OFS_CAUSE, 8'h00);
      src_mdl.drop(b);
    end
  endtask

  task automatic t_clk();
    logic s;
    for (int m = 0; m < 8; m++) begin
      CFG_MODE = m[2:0];
      repeat (2) @(posedge MCLK);
      #1 chk("clk sel cfg", m == 5 ? sbc_pkg::SBC_CLK_HOST : sbc_pkg::SBC_CLK_CONFIG, BUS_CLK_SEL);
    end
    CFG_MODE = 0;
    CONFIG_DONE = 1;
    repeat (2) @(posedge MCLK);
    #1 chk("clk sel done", sbc_pkg::SBC_CLK_FABRIC, BUS_CLK_SEL);
    CONFIG_BUSY = 1;
    repeat (2) @(posedge MCLK);
    #1 chk("clk sel busy", sbc_pkg::SBC_CLK_CONFIG, BUS_CLK_SEL);
    s = SYNC_CLK;
    @(posedge MCLK);
    #1 chk("sync clk", !s, SYNC_CLK);
  endtask

  task automatic t_brst();
    bus(2, `SBC_OFS_FAB_EN, 1, 8'hFF);
    @(posedge MCLK);
    #1 BUS_CORE_RESET_N = 0;
    repeat (2) @(posedge MCLK);
    #1 BUS_CORE_RESET_N = 1;
    rd(1, `SBC_OFS_FAB_EN, `SBC_EN_RST);
    rd(1, `SBC_OFS_HOST_EN, `SBC_EN_RST);
  endtask

  initial begin
    req = '{0, 0, 0};
    we = '{0, 0, 0};
    adr = '{0, 0, 0};
    wd = '{0, 0, 0};
    repeat (10) @(posedge MCLK);
    #1 RESET = 0;
    t_reset();
    t_arb();
    t_slave();
    t_regs();
    t_irq();
    t_clk();
    t_brst();
    end_of_test();
  end

  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end
endmodule
